// ### rtl/spdc_pkg.sv
// Constants, register map and field layout for the serial port default configuration block.
// Assumes a single 250 MHz clock and an APB register bus.
package spdc_pkg;
    // ******************************************************************
    // Register map (byte addresses, one word each)
    // ******************************************************************
    localparam logic [11:0] SPDC_FORMAT_OFS = 12'h000;
    localparam logic [11:0] SPDC_CTRL_OFS = 12'h004;
    localparam logic [11:0] SPDC_STATUS_OFS = 12'h008;
    localparam logic [11:0] SPDC_RATE_OFS = 12'h00C;
    localparam logic [11:0] SPDC_SEL_OFS = 12'h010;

    // ******************************************************************
    // Format word fields
    // ******************************************************************
    localparam int SPDC_STOP_LSB = 6;
    localparam int SPDC_PTYPE_BIT = 5;
    localparam int SPDC_PEN_BIT = 4;
    localparam int SPDC_LEN_LSB = 2;
    localparam int SPDC_RES_LSB = 0;

    // Control bits
    localparam int SPDC_CTRL_IFRST_BIT = 0;

    // Clock and rate table
    localparam int SPDC_CLK_MHZ = 250;
    localparam int SPDC_CLK_HZ = SPDC_CLK_MHZ * 1000000;
    localparam logic [3:0] SPDC_SELECT_CODE_STD = 4'hA;
    localparam logic [3:0] SPDC_SELECT_CODE_MODEM = 4'hB;

    typedef enum logic [1:0] {
        SPDC_STOP_BAD = 2'h0,
        SPDC_STOP_ONE = 2'h1,
        SPDC_STOP_ONE_HALF = 2'h2,
        SPDC_STOP_TWO = 2'h3
    } spdc_stop_t;

    typedef enum logic [1:0] {
        SPDC_RES_BAD = 2'h0,
        SPDC_RES_X1 = 2'h1,
        SPDC_RES_X16 = 2'h2,
        SPDC_RES_X64 = 2'h3
    } spdc_res_t;

    // Half-period of the bit-rate clock for each selector position
    function automatic logic [23:0] spdc_rate_half(input logic [3:0] pos);
        int bps;
        case (pos)
            4'h1: bps = 9600;
            4'h2: bps = 4800;
            4'h3: bps = 2400;
            4'h4: bps = 1800;
            4'h5: bps = 1200;
            4'h6: bps = 600;
            4'h7: bps = 300;
            4'h8: bps = 150;
            4'h9: bps = 110;
            default: bps = 75;
        endcase
        return 24'(SPDC_CLK_HZ / (2 * bps));
    endfunction : spdc_rate_half
endpackage : spdc_pkg

// ### rtl/spdc_top.sv
// Configuration core of the serial port: default format, rate clock, clock and line options.
// Assumes switch inputs synchronous to pclk and a conforming APB master.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spdc_top
    import spdc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] sw_format,
    input wire logic [3:0] sw_rate,
    input wire logic [3:0] sw_select,
    input wire logic [3:0] bus_select,
    input wire logic sw_loop_mode,
    input wire logic sw_tx_ext,
    input wire logic sw_rx_ext,
    input wire logic sw_cts_force,
    input wire logic ext_tx_clk,
    input wire logic ext_rx_clk,
    input wire logic cts_in,
    input wire logic rts_in,
    input wire logic dsr_ctl,
    output logic cts_out,
    output logic rts_out,
    output logic dsr_out,
    output logic rate_clk,
    output logic tx_clk,
    output logic rx_clk,
    output logic [1:0] stop_sel,
    output logic parity_en,
    output logic parity_even,
    output logic [1:0] char_len,
    output logic [1:0] res_sel
);

    // ******************************************************************
    // APB decode
    // ******************************************************************
    logic [7:0] format_word;
    logic if_reset;
    logic [23:0] rate_cnt;
    logic [3:0] rate_pos;
    logic sel_hit;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign sel_hit = (bus_select == sw_select);
    assign addr_ok = (paddr == SPDC_FORMAT_OFS) || (paddr == SPDC_CTRL_OFS)
                     || (paddr == SPDC_STATUS_OFS) || (paddr == SPDC_RATE_OFS)
                     || (paddr == SPDC_SEL_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || !sel_hit);
    assign wr_en = psel && penable && pwrite && sel_hit;
    assign rd_en = psel && penable && !pwrite && sel_hit;

    // ******************************************************************
    // Format word
    // ******************************************************************
    // No asynchronous reset here; the switch levels are captured on each clock
    // while the reset stays low, on the first clock after it and on an interface reset.
    logic rst_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen <= 1'b1;
        end else begin
            rst_seen <= 1'b0;
        end
    end

    always_ff @(posedge pclk) begin
        if (!presetn || rst_seen || if_reset) begin
            format_word <= sw_format;
        end else if (wr_en && paddr == SPDC_FORMAT_OFS) begin
            format_word <= pwdata[7:0];
        end
    end

    // Self-clearing interface reset strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if_reset <= 1'b0;
        end else begin
            if_reset <= wr_en && paddr == SPDC_CTRL_OFS && pwdata[SPDC_CTRL_IFRST_BIT];
        end
    end

    // Field decode; 00 resolution is left to the host to avoid
    always_comb begin
        stop_sel = format_word[SPDC_STOP_LSB +: 2];
        parity_en = format_word[SPDC_PEN_BIT];
        parity_even = format_word[SPDC_PTYPE_BIT];
        char_len = format_word[SPDC_LEN_LSB +: 2];
        res_sel = format_word[SPDC_RES_LSB +: 2];
    end

    // ******************************************************************
    // Rate clock generator
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_pos <= 4'h0;
        end else begin
            rate_pos <= sw_rate;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt <= 24'h000000;
            rate_clk <= 1'b0;
        end else if (rate_cnt + 24'h000001 >= spdc_rate_half(rate_pos)) begin
            rate_cnt <= 24'h000000;
            rate_clk <= ~rate_clk;
        end else begin
            rate_cnt <= rate_cnt + 24'h000001;
        end
    end

    // ******************************************************************
    // Clock selection and line control
    // ******************************************************************
    // External clocks are sampled; caller supplies a 50% duty clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_clk <= 1'b0;
            rx_clk <= 1'b0;
        end else begin
            tx_clk <= sw_tx_ext ? ext_tx_clk : rate_clk;
            rx_clk <= sw_rx_ext ? ext_rx_clk : rate_clk;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_out <= 1'b0;
            rts_out <= 1'b0;
            dsr_out <= 1'b0;
        end else begin
            cts_out <= !sw_loop_mode && (sw_cts_force || cts_in);
            rts_out <= !sw_loop_mode && rts_in;
            dsr_out <= !sw_loop_mode && dsr_ctl;
        end
    end

    // ******************************************************************
    // Read mux
    // ******************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite && !sel_hit) begin
            // Refused reads return zero so another card's code leaks nothing
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                SPDC_FORMAT_OFS: prdata <= {24'h000000, format_word};
                SPDC_STATUS_OFS: prdata <= {26'h0, sw_loop_mode, sw_cts_force,
                                            sw_rx_ext, sw_tx_ext, tx_clk, rx_clk};
                SPDC_RATE_OFS: prdata <= {28'h0000000, rate_pos};
                SPDC_SEL_OFS: prdata <= {28'h0000000, sw_select};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    a_fmt_load: assert property (@(posedge pclk) disable iff (!presetn)
        if_reset |=> format_word == $past(sw_format))
        else $error("format not reloaded on interface reset");
    a_fmt_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == SPDC_FORMAT_OFS && !rst_seen && !if_reset)
        |=> format_word == $past(pwdata[7:0]))
        else $error("format write lost");
    a_fmt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_en && !if_reset && !rst_seen) |=> $stable(format_word))
        else $error("format changed without cause");
    a_sel_block: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !sel_hit) |-> pslverr && !wr_en)
        else $error("access accepted at wrong select code");
    a_loop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        sw_loop_mode [*2] |-> !cts_out && !rts_out && !dsr_out)
        else $error("control line active in current loop");
    a_cts_force: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_cts_force && !sw_loop_mode) |=> cts_out)
        else $error("clear to send not forced");
    a_tx_sel: assert property (@(posedge pclk) disable iff (!presetn)
        sw_tx_ext |=> tx_clk == $past(ext_tx_clk))
        else $error("tx clock select wrong");
    a_stop_map: assert property (@(posedge pclk) disable iff (!presetn)
        stop_sel == format_word[7:6] && char_len == format_word[3:2]
        && res_sel == format_word[1:0])
        else $error("field mapping wrong");
    a_rate_bound: assert property (@(posedge pclk) disable iff (!presetn)
        rate_cnt < spdc_rate_half(rate_pos) || $changed(rate_pos))
        else $error("rate counter overran");

    // ******************************************************************
    // Bus checks
    // ******************************************************************
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        pready)
        else $error("ready not high");

    a_wr_gate: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en |-> sel_hit && psel && penable)
        else $error("write outside own select code");

    a_rd_gate: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en |-> sel_hit && psel && penable)
        else $error("read outside own select code");

    a_err_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !addr_ok) |-> pslverr)
        else $error("unmapped access not refused");

    a_err_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && addr_ok && sel_hit) |-> !pslverr)
        else $error("good access refused");

    a_err_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |-> !pslverr)
        else $error("error outside access phase");

    a_rd_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !sel_hit) |=> prdata == 32'h00000000)
        else $error("read data at wrong select code");

    a_rd_format: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_hit && paddr == SPDC_FORMAT_OFS)
        |=> prdata == {24'h000000, $past(format_word)})
        else $error("format readback wrong");

    a_rd_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_hit && paddr == SPDC_RATE_OFS)
        |=> prdata == {28'h0000000, $past(rate_pos)})
        else $error("rate position readback wrong");

    a_rd_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_hit && paddr == SPDC_SEL_OFS)
        |=> prdata == {28'h0000000, $past(sw_select)})
        else $error("select code readback wrong");

    a_rd_status: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && sel_hit && paddr == SPDC_STATUS_OFS)
        |=> prdata[5:0] == $past({sw_loop_mode, sw_cts_force, sw_rx_ext, sw_tx_ext,
                                  tx_clk, rx_clk}))
        else $error("status readback wrong");

    a_rd_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == SPDC_CTRL_OFS)
        |=> prdata == 32'h00000000)
        else $error("control read not zero");

    a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !addr_ok) |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_rd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");

    // ******************************************************************
    // Reset, strobe, format write and parity field checks
    // ******************************************************************
    a_first_load: assert property (@(posedge pclk) disable iff (!presetn)
        rst_seen |=> format_word == $past(sw_format))
        else $error("switches not loaded after reset");

    a_rst_once: assert property (@(posedge pclk) disable iff (!presetn)
        rst_seen |=> !rst_seen)
        else $error("reset marker stuck");

    a_ifrst_cause: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == SPDC_CTRL_OFS && pwdata[SPDC_CTRL_IFRST_BIT]) |=> if_reset)
        else $error("interface reset not raised");

    a_ifrst_only: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == SPDC_CTRL_OFS) |=> !if_reset)
        else $error("interface reset without write");

    a_ifrst_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        if_reset |=> !if_reset)
        else $error("interface reset longer than one cycle");

    a_other_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr != SPDC_FORMAT_OFS && !if_reset && !rst_seen)
        |=> $stable(format_word))
        else $error("format moved on other write");

    a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !sel_hit && !if_reset && !rst_seen)
        |=> $stable(format_word))
        else $error("format moved at wrong select code");

    a_par_en: assert property (@(posedge pclk) disable iff (!presetn)
        parity_en == format_word[4])
        else $error("parity enable mapping wrong");

    a_par_type: assert property (@(posedge pclk) disable iff (!presetn)
        parity_even == format_word[5])
        else $error("parity type mapping wrong");

    // ******************************************************************
    // Clock and line checks
    // ******************************************************************
    a_rate_pos: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> rate_pos == $past(sw_rate))
        else $error("rate position not followed");

    a_rate_edge: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(rate_clk) |-> rate_cnt == 24'h000000)
        else $error("rate clock toggled mid count");

    a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        rate_cnt != 24'h000000 |-> rate_cnt == $past(rate_cnt) + 24'h000001)
        else $error("rate counter skipped");

    a_rx_sel: assert property (@(posedge pclk) disable iff (!presetn)
        sw_rx_ext |=> rx_clk == $past(ext_rx_clk))
        else $error("rx clock select wrong");

    a_tx_int: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_tx_ext |=> tx_clk == $past(rate_clk))
        else $error("tx internal clock wrong");

    a_rx_int: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_rx_ext |=> rx_clk == $past(rate_clk))
        else $error("rx internal clock wrong");

    a_cts_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (!sw_cts_force && !sw_loop_mode) |=> cts_out == $past(cts_in))
        else $error("clear to send not passed");

    a_rts_pass: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_loop_mode |=> rts_out == $past(rts_in))
        else $error("request to send not passed");

    a_dsr_pass: assert property (@(posedge pclk) disable iff (!presetn)
        !sw_loop_mode |=> dsr_out == $past(dsr_ctl))
        else $error("data set ready not passed");
endmodule : spdc_top
`default_nettype wire

// ### tb/serial_port_default_config_tb_top.sv
// Self-checking bench for the serial port configuration core.
// Assumes the line partner model and an APB master built from tasks here.
`timescale 1ns/1ps
`default_nettype none
module serial_port_default_config_tb_top import spdc_pkg::*; ();
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, prv, pr2, run_clk = 1'b0;
    logic [7:0] sw_format = 8'hCF;
    // 2400 while the format holds 1/64, so the fast rates never meet it
    logic [3:0] sw_rate = 4'h3, sw_select = 4'hA, bus_select = 4'hA;
    logic sw_loop_mode = 1'b0, sw_tx_ext = 1'b0, sw_rx_ext = 1'b0, sw_cts_force = 1'b0;
    logic [2:0] lvl = 3'h0;
    wire ext_tx_clk, ext_rx_clk, cts_in, rts_in, dsr_ctl, cts_out, rts_out, dsr_out;
    wire rate_clk, tx_clk, rx_clk, parity_en, parity_even;
    wire [1:0] stop_sel, char_len, res_sel;
    wire [7:0] fields = {stop_sel, parity_even, parity_en, char_len, res_sel};
    // No word has a zero resolution field
    logic [7:0] fmt [4] = '{8'h35, 8'h5A, 8'hA3, 8'hFE};
    int failures = 0, total_checks = 0, cyc = 0, n;

    always #2 pclk = ~pclk;

    spdc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sw_format, .sw_rate, .sw_select, .bus_select, .sw_loop_mode,
        .sw_tx_ext, .sw_rx_ext, .sw_cts_force, .ext_tx_clk, .ext_rx_clk, .cts_in, .rts_in,
        .dsr_ctl, .cts_out, .rts_out, .dsr_out, .rate_clk, .tx_clk, .rx_clk, .stop_sel,
        .parity_en, .parity_even, .char_len, .res_sel);

    spdc_line_partner partner (.pclk, .run_clk, .lvl, .ext_tx_clk, .ext_rx_clk, .cts_in,
        .rts_in, .dsr_ctl);

    // ******************************************************************
    // Bus master, comparison and closing
    // ******************************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Longest test is two rate-clock half periods at 9600, about 26k cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(fields, 8'hCF);
        apb(1'b0, SPDC_RATE_OFS, 32'h0);
        chk(q, 32'h3);
        chk(pready, 1'b1);
        foreach (fmt[i]) begin
            apb(1'b1, SPDC_FORMAT_OFS, {24'h0, fmt[i]});
            @(posedge pclk);
            chk(fields, fmt[i]);
        end
        apb(1'b0, SPDC_FORMAT_OFS, 32'h0);
        chk(q, 32'hFE);
        apb(1'b0, SPDC_SEL_OFS, 32'h0);
        chk(q, 32'hA);
        sw_format <= 8'h6D;
        repeat (4) @(posedge pclk);
        chk(fields, 8'hFE);
        apb(1'b1, SPDC_CTRL_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        chk(fields, 8'h6D);
        bus_select <= 4'hB;
        apb(1'b1, SPDC_FORMAT_OFS, 32'h5A);
        chk(err, 1'b1);
        apb(1'b0, SPDC_FORMAT_OFS, 32'h0);
        chk(q, 32'h0);
        bus_select <= 4'hA;
        apb(1'b0, 12'h014, 32'h0);
        chk(err, 1'b1);
        chk(fields, 8'h6D);
        lvl <= 3'h3;
        repeat (3) @(posedge pclk);
        chk({cts_out, rts_out, dsr_out}, 3'h3);
        sw_cts_force <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({cts_out, rts_out, dsr_out}, 3'h7);
        sw_loop_mode <= 1'b1;
        lvl <= 3'h7;
        repeat (3) @(posedge pclk);
        chk({cts_out, rts_out, dsr_out}, 3'h0);
        sw_loop_mode <= 1'b0;
        sw_tx_ext <= 1'b1;
        run_clk <= 1'b1;
        repeat (4) @(posedge pclk);
        prv = ext_tx_clk;
        pr2 = rate_clk;
        repeat (12) begin
            @(posedge pclk);
            chk(tx_clk, prv);
            chk(rx_clk, pr2);
            prv = ext_tx_clk;
            pr2 = rate_clk;
        end
        sw_tx_ext <= 1'b0;
        sw_rx_ext <= 1'b1;
        repeat (4) @(posedge pclk);
        prv = ext_rx_clk;
        pr2 = rate_clk;
        repeat (12) begin
            @(posedge pclk);
            chk(rx_clk, prv);
            chk(tx_clk, pr2);
            prv = ext_rx_clk;
            pr2 = rate_clk;
        end
        // Reset in mid-run: the line outputs clear, then the switches win over the written word
        apb(1'b1, SPDC_FORMAT_OFS, 32'h35);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({cts_out, rts_out, dsr_out}, 3'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(fields, 8'h6D);
        // Measure one half period from toggle to toggle at position 1
        sw_rate <= 4'h1;
        repeat (2) @(posedge pclk);
        prv = rate_clk;
        while (rate_clk === prv) @(posedge pclk);
        prv = rate_clk;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rate_clk === prv);
        chk(n, 32'(SPDC_CLK_HZ / 19200));
        tally_and_finish();
    end
endmodule : serial_port_default_config_tb_top
`default_nettype wire

// ### tb/spdc_line_partner.sv
// Far-side line model: terminal or modem handshake levels and external clocks.
// Assumes the bench clock; every output changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module spdc_line_partner #(
    parameter int HALF = 3
) (
    input wire logic pclk,
    input wire logic run_clk,
    input wire logic [2:0] lvl,
    output logic ext_tx_clk,
    output logic ext_rx_clk,
    output logic cts_in,
    output logic rts_in,
    output logic dsr_ctl
);
    int cnt = 0;
    initial begin
        ext_tx_clk = 1'b0;
        ext_rx_clk = 1'b0;
    end
    // Equal high and low times; stands low when not asked to run
    always @(posedge pclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (!run_clk) begin
            ext_tx_clk <= 1'b0;
            ext_rx_clk <= 1'b0;
        end else if (cnt == HALF - 1) begin
            ext_tx_clk <= ~ext_tx_clk;
            ext_rx_clk <= ~ext_rx_clk;
        end
    end
    assign {cts_in, rts_in, dsr_ctl} = lvl;
endmodule : spdc_line_partner
`default_nettype wire
